// ===== dv/gpc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************
// Board side of the pin
// ****************************
module gpc_pin_model (
    input wire logic pinOut,
    input wire logic pinOutEnN,
    input wire logic extLevel,
    output logic pinIn
);
    // Released pin follows the board level, which idles high on a pull-up
    assign pinIn = pinOutEnN ? extLevel : pinOut;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam logic [8:0] CF = gpc_pkg::CFG_ADDR;
    localparam logic [8:0] DA = gpc_pkg::DATA_ADDR;
    localparam logic [8:0] ST = gpc_pkg::STAT_ADDR;
    localparam logic [8:0] MK = gpc_pkg::MASK_ADDR;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hardReset = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic extLevel = 1'b1;
    logic [8:0] adr = 9'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack, pinIn, pinOut, pinOutEnN, dre, irq;
    logic [7:0] cf [3] = '{8'h01, 8'h09, 8'h0D};
    logic ie [3] = '{1'b0, 1'b0, 1'b1};
    int err_total = 0;
    int cmp_count = 0;
    always #10 mclk = ~mclk;
    gpc_gpio_4_3 gpc_gpio_4_3_inst (.mclk(mclk), .rst(rst), .hardReset(hardReset),
        .cyc_i(cyc), .stb_i(cyc), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .pinIn(pinIn), .pinOut(pinOut),
        .pinOutEnN(pinOutEnN), .disableRegWriteEn(dre), .irq(irq));
    gpc_pin_model gpc_pin_model_inst (.pinOut(pinOut), .pinOutEnN(pinOutEnN),
        .extLevel(extLevel), .pinIn(pinIn));
    // ****************************
    // Bus and check tasks
    // ****************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Sampled just after the edge, so ack is the value seen at it
    task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic pin(input logic v);
        @(posedge mclk);
        extLevel <= v;
    endtask
    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****************************
    // Tests
    // ****************************
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        wb(0, CF, 0);
        chk(q, 32'h01);
        wb(1, CF, 32'h00);
        wb(1, DA, 32'h01);
        look(1);
        chk(32'({pinOutEnN, pinOut}), 32'h1);
        wb(1, CF, 32'h02);
        look(1);
        chk(32'(pinOut), 32'h0);
        wb(1, CF, 32'h80);
        look(1);
        chk(32'({pinOutEnN, pinOut}), 32'h2);
        wb(1, DA, 32'h00);
        look(1);
        chk(32'({pinOutEnN, pinOut}), 32'h0);
        wb(1, CF, 32'h73);
        wb(0, CF, 0);
        chk(q, 32'h03);
        wb(0, DA, 0);
        chk(q, 32'h0);
        chk(32'(pinOutEnN), 32'h1);
        wb(0, 9'h000, 0);
        chk(q, 32'h0);
        wb(1, MK, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wb(1, CF, 32'(cf[i]));
            wb(1, ST, 32'h3);
            wb(0, CF, 0);
            chk(q, 32'(cf[i]));
            pin(~extLevel);
            look(4);
            chk(32'(irq), 32'(ie[i]));
        end
        wb(0, ST, 0);
        chk(q, 32'h1);
        wb(1, ST, 32'h1);
        look(2);
        chk(32'(irq), 32'h0);
        wb(1, CF, 32'h07);
        pin(1);
        look(3);
        chk(32'(pinOutEnN), 32'h1);
        chk(32'(dre), 32'h0);
        wb(0, DA, 0);
        chk(32'(q[0]), 32'h1);
        wb(0, ST, 0);
        chk(q, 32'h2);
        pin(0);
        look(3);
        chk(32'(dre), 32'h1);
        wb(1, CF, 32'h83);
        wb(0, CF, 0);
        chk(q, 32'h87);
        @(posedge mclk);
        hardReset <= 1'b1;
        @(posedge mclk);
        hardReset <= 1'b0;
        wb(0, CF, 0);
        chk(q, 32'h83);
        wb(1, CF, 32'h04);
        @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        wb(0, CF, 0);
        chk(q, 32'h01);
        report_and_stop();
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== verilog/gpc_gpio_4_3.sv
// Function
// - Direction bit one makes the pin input, zero makes it output.
// - Polarity bit one inverts the pin value, zero passes it.
// - Function 11 is either-edge interrupt three, 10 reserved, 00 plain GPIO.
// - Function 01 forces input, non-inverted, overriding direction and polarity.
// - Once function is 01, software writes to the field are ignored.
// - Power-on resets and hard reset clear the function field; only release.
// - Locked and pin high: disable register is read-only, writes discarded.
// - Locked and pin low: disable register is readable and writable.
// - Output type one gives open drain, zero gives push-pull.
`timescale 1ns/1ns
`default_nettype none

module gpc_gpio_4_3 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic hardReset,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [gpc_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOutEnN,
    output logic disableRegWriteEn,
    output logic irq
);

    // ****************************************
    // State
    // ****************************************
    gpc_pkg::gpc_cfg_t cfg_reg;
    gpc_pkg::gpc_cfg_t cfg_next;
    gpc_pkg::gpc_cfg_t wrCfg;
    gpc_pkg::gpc_pad_t pad_reg;
    gpc_pkg::gpc_pad_t pad_next;
    logic outLatch_reg;
    logic outLatch_next;
    logic pinSmp_reg;
    logic pinPrev_reg;
    logic [gpc_pkg::ST_W-1:0] stat_reg;
    logic [gpc_pkg::ST_W-1:0] stat_next;
    logic [gpc_pkg::ST_W-1:0] mask_reg;
    logic [gpc_pkg::ST_W-1:0] mask_next;
    logic [gpc_pkg::ST_W-1:0] statSet;
    logic [gpc_pkg::ST_W-1:0] statClr;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdData_reg;
    logic [31:0] rdData_next;
    logic wrEn_reg;
    logic wrEn_next;
    logic irq_reg;
    logic irq_next;

    // ****************************************
    // Bus decode
    // ****************************************
    logic [gpc_pkg::ADR_W-1:0] wordAdr;
    logic busReq;
    logic wrStrobe;
    logic hitCfg;
    logic hitData;
    logic hitStat;
    logic hitMask;
    logic cfgWr;
    logic [31:0] readMux;

    assign wordAdr = {adr_i[gpc_pkg::ADR_W-1:2], 2'h0};
    assign busReq = cyc_i & stb_i;
    // Write lands on the edge where ack is seen high
    assign wrStrobe = busReq & we_i & ack_reg & sel_i[0];
    assign hitCfg = wordAdr == gpc_pkg::CFG_ADDR;
    assign hitData = wordAdr == gpc_pkg::DATA_ADDR;
    assign hitStat = wordAdr == gpc_pkg::STAT_ADDR;
    assign hitMask = wordAdr == gpc_pkg::MASK_ADDR;
    assign cfgWr = wrStrobe & hitCfg;
    assign wrCfg = dat_i[7:0];

    // ****************************************
    // Pin behaviour
    // ****************************************
    logic funcLocked;
    logic effIn;
    logic effPol;
    logic driveVal;
    logic pinLogic;
    logic edgeEv;
    logic lockEv;

    assign funcLocked = cfg_reg.func == gpc_pkg::FUNC_WP;
    assign effIn = funcLocked | cfg_reg.dir;
    assign effPol = ~funcLocked & cfg_reg.pol;
    assign driveVal = outLatch_reg ^ effPol;
    assign pinLogic = pinSmp_reg ^ effPol;
    // Open drain only ever pulls low; a one releases the pin
    assign pad_next.out = cfg_reg.outType ? 1'b0 : driveVal;
    assign pad_next.enN = effIn | (cfg_reg.outType & driveVal);
    assign edgeEv = (cfg_reg.func == gpc_pkg::FUNC_IRQ) & (pinSmp_reg != pinPrev_reg);
    assign lockEv = cfgWr & ~funcLocked & ~hardReset & (wrCfg.func == gpc_pkg::FUNC_WP);
    // Pin only gates the disable register while locked
    assign wrEn_next = ~funcLocked | ~pinSmp_reg;

    // ****************************************
    // Configuration update
    // ****************************************
    always_comb begin
        cfg_next = cfg_reg;
        if (cfgWr) begin
            cfg_next.dir = wrCfg.dir;
            cfg_next.pol = wrCfg.pol;
            cfg_next.outType = wrCfg.outType;
            if (!funcLocked) begin
                cfg_next.func = wrCfg.func;
            end
        end
        if (hardReset) begin
            cfg_next.func = gpc_pkg::FUNC_GPIO;
        end
        cfg_next.rsv = gpc_pkg::RSV_ZERO;
    end

    // ****************************************
    // Registers and interrupts
    // ****************************************
    assign outLatch_next = (wrStrobe & hitData) ? dat_i[0] : outLatch_reg;
    assign mask_next = (wrStrobe & hitMask) ? dat_i[gpc_pkg::ST_W-1:0] : mask_reg;
    assign statSet = {lockEv, edgeEv};
    assign statClr = (wrStrobe & hitStat) ? dat_i[gpc_pkg::ST_W-1:0] : '0;
    // Set beats a clear in the same cycle
    assign stat_next = (stat_reg & ~statClr) | statSet;
    assign irq_next = |(stat_reg & mask_reg);
    assign ack_next = busReq & ~ack_reg;
    assign readMux = hitCfg ? {24'h000000, cfg_reg} :
                     hitData ? {30'h00000000, outLatch_reg, pinLogic} :
                     hitStat ? {30'h00000000, stat_reg} :
                     hitMask ? {30'h00000000, mask_reg} : 32'h00000000;
    assign rdData_next = (busReq & ~ack_reg) ? readMux : rdData_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_reg <= gpc_pkg::CFG_RESET;
            outLatch_reg <= 1'b0;
            pinSmp_reg <= 1'b0;
            pinPrev_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            outLatch_reg <= outLatch_next;
            pinSmp_reg <= pinIn;
            pinPrev_reg <= pinSmp_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pad_reg <= 2'h1;
            stat_reg <= '0;
            mask_reg <= '0;
            irq_reg <= 1'b0;
            wrEn_reg <= 1'b1;
        end else begin
            pad_reg <= pad_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            wrEn_reg <= wrEn_next;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdData_reg <= 32'h00000000;
        end else begin
            ack_reg <= ack_next;
            rdData_reg <= rdData_next;
        end
    end

    assign dat_o = rdData_reg;
    assign ack_o = ack_reg;
    assign pinOut = pad_reg.out;
    assign pinOutEnN = pad_reg.enN;
    assign disableRegWriteEn = wrEn_reg;
    assign irq = irq_reg;

    // ****************************************
    // Checks
    // ****************************************
    a_dir_input_release: assert property (@(posedge mclk) disable iff (rst)
        (cfg_reg.dir || funcLocked) |=> pinOutEnN)
        else $error("pin driven while configured as input");

    a_dir_output_drive: assert property (@(posedge mclk) disable iff (rst)
        (!cfg_reg.dir && !funcLocked && !cfg_reg.outType) |=> !pinOutEnN)
        else $error("push-pull output not driven");

    a_pol_drive_value: assert property (@(posedge mclk) disable iff (rst)
        (!effIn && !cfg_reg.outType) |=> pinOut == ($past(outLatch_reg) ^ $past(cfg_reg.pol)))
        else $error("driven level ignores polarity");

    a_edge_int_set: assert property (@(posedge mclk) disable iff (rst)
        (cfg_reg.func == gpc_pkg::FUNC_IRQ && $changed(pinSmp_reg)) ##1 1'b1 |=> stat_reg[0])
        else $error("pin edge did not set interrupt status");

    a_lock_hold_func: assert property (@(posedge mclk) disable iff (rst)
        (funcLocked && !hardReset) |=> funcLocked)
        else $error("locked function field changed");

    a_hard_clear_func: assert property (@(posedge mclk) disable iff (rst)
        hardReset |=> cfg_reg.func == gpc_pkg::FUNC_GPIO)
        else $error("hard reset left function field set");

    a_wp_pin_high: assert property (@(posedge mclk) disable iff (rst)
        (funcLocked && pinSmp_reg) |=> !disableRegWriteEn)
        else $error("disable register writable with pin high");

    a_wp_pin_low: assert property (@(posedge mclk) disable iff (rst)
        (funcLocked && !pinSmp_reg) |=> disableRegWriteEn)
        else $error("disable register locked with pin low");

    a_open_drain_high: assert property (@(posedge mclk) disable iff (rst)
        (!effIn && cfg_reg.outType && driveVal) |=> pinOutEnN && !pinOut)
        else $error("open drain drove a high level");

    a_rsv_read_zero: assert property (@(posedge mclk) disable iff (rst)
        (busReq && !ack_reg && hitCfg) |=> dat_o[6:4] == 3'h0)
        else $error("reserved bits read nonzero");

    a_ack_single: assert property (@(posedge mclk) disable iff (rst)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    a_ack_after_req: assert property (@(posedge mclk) disable iff (rst)
        (busReq && !ack_reg) |=> ack_o)
        else $error("request not answered in the next cycle");

    a_ack_no_req: assert property (@(posedge mclk) disable iff (rst)
        !busReq |=> !ack_o)
        else $error("ack given without a request");

    a_rd_data_hold: assert property (@(posedge mclk) disable iff (rst)
        (!busReq || ack_reg) |=> $stable(dat_o))
        else $error("read data moved without a new request");

    a_edge_func_only: assert property (@(posedge mclk) disable iff (rst)
        (cfg_reg.func != gpc_pkg::FUNC_IRQ && !stat_reg[0]) |=> !stat_reg[0])
        else $error("edge status set outside interrupt mode");

    a_lock_input_read: assert property (@(posedge mclk) disable iff (rst)
        (busReq && !ack_reg && hitData && funcLocked) |=> dat_o[0] == $past(pinSmp_reg))
        else $error("locked pin read back inverted");

    a_lock_write_drop: assert property (@(posedge mclk) disable iff (rst)
        (funcLocked && cfgWr && !hardReset) |=> cfg_reg.func == gpc_pkg::FUNC_WP)
        else $error("write changed the locked function field");

    a_lock_status_set: assert property (@(posedge mclk) disable iff (rst)
        $rose(funcLocked) |-> stat_reg[1])
        else $error("lock did not set its status bit");

    a_hard_keep_rest: assert property (@(posedge mclk) disable iff (rst)
        (hardReset && !cfgWr) |=> cfg_reg.dir == $past(cfg_reg.dir)
            && cfg_reg.pol == $past(cfg_reg.pol))
        else $error("hard reset touched bits outside the function field");

    a_wp_off_writable: assert property (@(posedge mclk) disable iff (rst)
        !funcLocked |=> disableRegWriteEn)
        else $error("disable register locked while not in control mode");

    a_open_drain_low: assert property (@(posedge mclk) disable iff (rst)
        (!effIn && cfg_reg.outType && !driveVal) |=> !pinOutEnN && !pinOut)
        else $error("open drain did not pull low");

    a_rsv_store_zero: assert property (@(posedge mclk) disable iff (rst)
        cfgWr |=> cfg_reg.rsv == gpc_pkg::RSV_ZERO)
        else $error("reserved bits stored a write");

    a_stat_w1c_clear: assert property (@(posedge mclk) disable iff (rst)
        (wrStrobe && hitStat && dat_i[0] && !edgeEv) |=> !stat_reg[0])
        else $error("status bit not cleared by writing one");

    a_irq_raise: assert property (@(posedge mclk) disable iff (rst)
        (|(stat_reg & mask_reg)) |=> irq)
        else $error("unmasked status did not raise interrupt");

    a_irq_drop: assert property (@(posedge mclk) disable iff (rst)
        !(|(stat_reg & mask_reg)) |=> !irq)
        else $error("interrupt high with no unmasked status");

    a_data_latch_write: assert property (@(posedge mclk) disable iff (rst)
        (wrStrobe && hitData) |=> outLatch_reg == $past(dat_i[0]))
        else $error("output latch missed a write");

    a_mask_write: assert property (@(posedge mclk) disable iff (rst)
        (wrStrobe && hitMask) |=> mask_reg == $past(dat_i[gpc_pkg::ST_W-1:0]))
        else $error("mask register missed a write");

endmodule

`default_nettype wire

// ===== verilog/gpc_pkg.sv
package gpc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADR_W = 9;
    localparam logic [7:0] CFG_INDEX = 8'h3E;
    localparam logic [ADR_W-1:0] CFG_ADDR = ADR_W'({CFG_INDEX, 2'h0});
    localparam logic [ADR_W-1:0] DATA_ADDR = 9'h100;
    localparam logic [ADR_W-1:0] STAT_ADDR = 9'h104;
    localparam logic [ADR_W-1:0] MASK_ADDR = 9'h108;

    // ****************************************
    // Field values
    // ****************************************
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [1:0] FUNC_GPIO = 2'h0;
    localparam logic [1:0] FUNC_WP = 2'h1;
    localparam logic [1:0] FUNC_RSV = 2'h2;
    localparam logic [1:0] FUNC_IRQ = 2'h3;
    localparam logic [2:0] RSV_ZERO = 3'h0;
    localparam int ST_EDGE = 0;
    localparam int ST_LOCK = 1;
    localparam int ST_W = 2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic outType;
        logic [2:0] rsv;
        logic [1:0] func;
        logic pol;
        logic dir;
    } gpc_cfg_t;

    typedef struct packed {
        logic out;
        logic enN;
    } gpc_pad_t;

endpackage
